/* design/adcsp_pkg.sv */
// Constants shared by the converter serial control port design
package adcsp_pkg;
   // ***********************************************
   // Timing
   // ***********************************************
   localparam int CLK_PERIOD_NS = 20;
   localparam int CS_SETUP_NS = 33;
   localparam int CS_SETUP_CYC =
      (CS_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int OSC_PERIOD_NS = 200;
   localparam int OSC_START_NS = 25;
   // Conversion takes 13.5 oscillator periods plus the oscillator start
   localparam int CONV_TIME_NS = (27 * OSC_PERIOD_NS) / 2 + OSC_START_NS;
   localparam int CONV_CYC = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // ***********************************************
   // Widths and counts
   // ***********************************************
   localparam int WORD_W = 16;
   localparam int CODE_W = 12;
   localparam int FIFO_DEPTH = 4;
   localparam logic [4:0] IN_BITS = 5'h08;
   localparam logic [4:0] SAMPLE_EDGE = 5'h04;
   localparam logic [4:0] LEN_8 = 5'h08;
   localparam logic [4:0] LEN_12 = 5'h0c;
   localparam logic [4:0] LEN_16 = 5'h10;
   localparam logic [1:0] LEN_SEL_8 = 2'h1;
   localparam logic [1:0] LEN_SEL_16 = 2'h3;
   // ***********************************************
   // Commands, fields and reset values
   // ***********************************************
   localparam logic [3:0] CMD_LAST_CHAN = 4'ha;
   localparam logic [3:0] CMD_TEST_MID = 4'hb;
   localparam logic [3:0] CMD_TEST_LO = 4'hc;
   localparam logic [3:0] CMD_TEST_HI = 4'hd;
   localparam logic [3:0] CMD_PWRDN = 4'he;
   localparam logic [3:0] CMD_SETUP = 4'hf;
   localparam logic [3:0] CHAN_ZERO = 4'h0;
   localparam logic [3:0] CFG_RESET = 4'h0;
   localparam int FMT_LEN_LO = 2;
   localparam int FMT_LSB_FIRST = 1;
   localparam int FMT_BIPOLAR = 0;
   localparam int SET_REF_LO = 2;
   localparam int SET_INT_MODE = 1;
   localparam int SET_DEFAULT = 0;
   localparam logic [1:0] REF_EXTERNAL = 2'h0;
   localparam logic [11:0] TEST_MID_CODE = 12'h800;
   localparam logic [11:0] TEST_LO_CODE = 12'h000;
   localparam logic [11:0] TEST_HI_CODE = 12'hfff;
   localparam logic [11:0] BIPOLAR_FLIP = 12'h800;
   localparam logic [2:0] PIN_RESET = 3'h1;
endpackage

/* design/adcsp_fifo.sv */
// Result FIFO with valid and ready on both sides
`timescale 1ns/1ns
`default_nettype none
module adcsp_fifo
   import adcsp_pkg::*;
#(
   parameter int WIDTH = WORD_W,
   parameter int DEPTH = FIFO_DEPTH
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic clk_en,
   // Fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // Drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int PW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [PW-1:0] wr_q;
   logic [PW-1:0] rd_q;
   logic [PW:0] cnt_q;
   logic push;
   logic pop;

   assign in_ready = (cnt_q != (PW+1)'(DEPTH));
   assign out_valid = (cnt_q != '0);
   assign out_data = mem_q[rd_q];
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;

   always_ff @(posedge mclk) begin
      if (clk_en && push) begin
         mem_q[wr_q] <= in_data;
      end
   end

   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
      end else if (clk_en) begin
         if (push) begin
            wr_q <= wr_q + 1'b1;
         end
         if (pop) begin
            rd_q <= rd_q + 1'b1;
         end
         if (push && !pop) begin
            cnt_q <= cnt_q + 1'b1;
         end else if (pop && !push) begin
            cnt_q <= cnt_q - 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

/* design/adcsp_conv.sv */
// Conversion timer on the internal oscillator, with result formatting
`timescale 1ns/1ns
`default_nettype none
module adcsp_conv
   import adcsp_pkg::*;
(
   // Clock and reset
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic clk_en,
   // Start and held sample
   input wire logic start,
   input wire logic [CODE_W-1:0] code_in,
   input wire logic [4:0] len,
   input wire logic lsb_first,
   input wire logic bipolar,
   output logic busy,
   // Result stream
   output logic out_valid,
   input wire logic out_ready,
   output logic [WORD_W-1:0] out_data
);
   localparam logic [12:0] CONV_LAST = 13'(CONV_CYC - 1);
   logic [12:0] cnt_q;
   logic run_q;
   logic hold_q;
   logic [CODE_W-1:0] code_q;
   logic [4:0] len_q;
   logic lsb_q;
   logic [WORD_W-1:0] word_q;
   logic [CODE_W-1:0] rev;

   assign busy = run_q | hold_q;
   assign out_valid = hold_q;
   assign out_data = word_q;

   // Bit reversal for LSB-first output
   genvar g;
   generate
      for (g = 0; g < CODE_W; g++) begin : g_rev
         assign rev[g] = code_q[CODE_W-1-g];
      end
   endgenerate

   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         run_q <= 1'b0;
         hold_q <= 1'b0;
         cnt_q <= '0;
         code_q <= '0;
         len_q <= LEN_16;
         lsb_q <= 1'b0;
         word_q <= '0;
      end else if (clk_en) begin
         if (start && !busy) begin
            run_q <= 1'b1;
            cnt_q <= CONV_LAST;
            code_q <= bipolar ? (code_in ^ BIPOLAR_FLIP) : code_in;
            len_q <= len;
            lsb_q <= lsb_first;
         end else if (run_q && cnt_q == '0) begin
            // Result held until the FIFO takes it
            run_q <= 1'b0;
            hold_q <= 1'b1;
            if (!lsb_q) begin
               word_q <= {code_q, 4'h0};
            end else if (len_q == LEN_8) begin
               word_q <= {rev[7:0], 8'h00};
            end else begin
               word_q <= {rev, 4'h0};
            end
         end else if (run_q) begin
            cnt_q <= cnt_q - 1'b1;
         end
         if (hold_q && out_ready) begin
            hold_q <= 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

/* design/adcsp_top.sv */
// Serial control and result port of a 12-bit converter
//
// Contract
// R1: Chip select high ignores clock and data input; data output floats.
// R2: Chip select low starts an I/O cycle and drives data output.
// R3: Input word is eight bits: command nibble then configuration nibble.
// R4: Non-setup commands load format: length, bit order, bipolar coding.
// R5: Setup holds reference select, end/done signalling and default mode.
// R6: Setup register loads only with the setup-access command code.
// R7: A cycle lasts 8, 12 or 16 clocks per current length.
// R8: Input bits arrive MSB first, one per rising edge, first eight.
// R9: Input after the eighth clock is ignored in long cycles.
// R10: Previous result shifts out in the same cycle, 8/12/16 bits.
// R11: Sampling starts on fourth falling edge, held at the last one.
// R12: Last falling edge starts conversion; end-of-conversion goes low.
// R13: With chip select held low, first bit follows result latch.
// R14: With chip select toggled, first bit appears at its falling edge.
// R15: Later output bits advance on each falling clock edge.
// R16: Control inputs are ignored for a setup interval after select falls.
// R17: Host programs setup with the access command before valid conversions.
// R18: Full setup programming needs at least eight clocks.
// R19: Cycle after setup loads format; third cycle gives first valid result.
// R20: Clearing the default bit leaves default mode from the next cycle.
// R21: Default mode: 16 clocks, MSB first, external reference, EOC, input 0.
// R22: Reset clears both configuration registers, status output high.
// R23: Done signal falls at latch, rises at select fall or clock rise.
// R24: Codes pick channels 0-10, three tests, power-down, setup access.
// R25: Data input held high for a cycle sets default mode.
// R26: Conversion runs on its own timer; result latched when complete.
`timescale 1ns/1ns
`default_nettype none
module adcsp_top
   import adcsp_pkg::*;
(
   // Clock, reset and enable
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic clk_en,
   // Serial pins
   input wire logic cs_n_pin,
   input wire logic io_clk_pin,
   input wire logic data_in_pin,
   output logic data_out,
   output logic data_out_oe,
   output logic eoc_int,
   // Analog front end
   input wire logic [CODE_W-1:0] sample_code,
   output logic [3:0] analog_channel,
   output logic [1:0] ref_select,
   output logic sampling,
   output logic power_down
);
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_GUARD,
      ST_XFER,
      ST_WAIT
   } adcsp_state_t;

   // ***********************************************
   // Pin synchronisers
   // ***********************************************
   // Bit order {data_in, io_clk, cs_n}; stage 1 feeds only stage 2
   logic [2:0] pin_s1_q;
   logic [2:0] pin_s2_q;
   logic [2:0] pin_s3_q;

   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         pin_s1_q <= PIN_RESET;
         pin_s2_q <= PIN_RESET;
         pin_s3_q <= PIN_RESET;
      end else if (clk_en) begin
         pin_s1_q <= {data_in_pin, io_clk_pin, cs_n_pin};
         pin_s2_q <= pin_s1_q;
         pin_s3_q <= pin_s2_q;
      end
   end

   logic cs_low;
   logic cs_fall;
   logic cs_rise;
   logic sclk_rise;
   logic sclk_fall;
   logic din;

   assign cs_low = ~pin_s2_q[0];
   assign cs_fall = pin_s3_q[0] & ~pin_s2_q[0];
   assign cs_rise = ~pin_s3_q[0] & pin_s2_q[0];
   assign sclk_rise = ~pin_s3_q[1] & pin_s2_q[1];
   assign sclk_fall = pin_s3_q[1] & ~pin_s2_q[1];
   assign din = pin_s2_q[2];

   // ***********************************************
   // Registers and derived modes
   // ***********************************************
   adcsp_state_t state_q;
   logic [3:0] fmt_q;
   logic [3:0] setup_q;
   logic [3:0] cmd_q;
   logic [6:0] in_sh_q;
   logic [4:0] rise_q;
   logic [4:0] fall_q;
   logic [4:0] len_q;
   logic [3:0] guard_q;
   logic [WORD_W-1:0] result_q;
   logic [WORD_W-1:0] out_sh_q;
   logic conv_start_q;

   logic dflt;
   logic int_mode;
   logic [4:0] len_now;
   logic lsb_now;
   logic [3:0] chan_now;
   logic [CODE_W-1:0] code_src;

   // Default mode overrides the programmed fields except bipolar coding [R21]
   assign dflt = setup_q[SET_DEFAULT];
   assign int_mode = ~dflt & setup_q[SET_INT_MODE];
   assign lsb_now = ~dflt & fmt_q[FMT_LSB_FIRST];
   assign chan_now = dflt ? CHAN_ZERO : cmd_q;

   always_comb begin
      if (dflt) begin
         len_now = LEN_16;
      end else if (fmt_q[3:FMT_LEN_LO] == LEN_SEL_8) begin
         len_now = LEN_8;
      end else if (fmt_q[3:FMT_LEN_LO] == LEN_SEL_16) begin
         len_now = LEN_16;
      end else begin
         len_now = LEN_12;
      end
   end

   // Test voltages replace the analog sample [R24]
   always_comb begin
      if (chan_now == CMD_TEST_MID) begin
         code_src = TEST_MID_CODE;
      end else if (chan_now == CMD_TEST_LO) begin
         code_src = TEST_LO_CODE;
      end else if (chan_now == CMD_TEST_HI) begin
         code_src = TEST_HI_CODE;
      end else begin
         code_src = sample_code;
      end
   end

   // ***********************************************
   // Conversion and result path
   // ***********************************************
   logic conv_busy;
   logic conv_valid;
   logic conv_ready;
   logic [WORD_W-1:0] conv_word;
   logic fifo_valid;
   logic fifo_ready;
   logic [WORD_W-1:0] fifo_word;
   logic latch;
   logic new_cycle;

   adcsp_conv u_conv (
      .mclk(mclk),
      .reset_n(reset_n),
      .clk_en(clk_en),
      .start(conv_start_q),
      .code_in(code_src),
      .len(len_now),
      .lsb_first(lsb_now),
      .bipolar(fmt_q[FMT_BIPOLAR]),
      .busy(conv_busy),
      .out_valid(conv_valid),
      .out_ready(conv_ready),
      .out_data(conv_word)
   );

   adcsp_fifo #(
      .WIDTH(WORD_W),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .mclk(mclk),
      .reset_n(reset_n),
      .clk_en(clk_en),
      .in_valid(conv_valid),
      .in_ready(conv_ready),
      .in_data(conv_word),
      .out_valid(fifo_valid),
      .out_ready(fifo_ready),
      .out_data(fifo_word)
   );

   // The output register never changes under a running transfer [R26]
   assign fifo_ready = (state_q == ST_WAIT) ||
                       (state_q == ST_IDLE && !cs_fall);
   assign latch = fifo_valid & fifo_ready;
   // Held select: next cycle opens as the result is latched [R13]
   assign new_cycle = (state_q == ST_WAIT) && cs_low && latch;

   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         result_q <= '0;
      end else if (clk_en && latch) begin
         result_q <= fifo_word; // [R26]
      end
   end

   // ***********************************************
   // Cycle sequencer
   // ***********************************************
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         state_q <= ST_IDLE;
      end else if (clk_en) begin
         case (state_q)
            ST_IDLE: begin
               if (cs_fall) begin
                  state_q <= ST_GUARD; // [R2]
               end
            end
            ST_GUARD: begin
               if (!cs_low) begin
                  state_q <= ST_IDLE;
               end else if (guard_q == 4'h0) begin
                  state_q <= ST_XFER; // [R16]
               end
            end
            ST_XFER: begin
               if (!cs_low) begin
                  state_q <= ST_IDLE; // [R1]
               end else if (sclk_fall && fall_q + 5'h01 == len_q) begin
                  state_q <= ST_WAIT; // [R7]
               end
            end
            ST_WAIT: begin
               if (!cs_low) begin
                  state_q <= ST_IDLE;
               end else if (new_cycle) begin
                  state_q <= ST_XFER;
               end
            end
            default: begin
               state_q <= ST_IDLE;
            end
         endcase
      end
   end

   // Setup guard after select falls; clocks meanwhile are dropped
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         guard_q <= '0;
      end else if (clk_en) begin
         if (state_q == ST_IDLE) begin
            guard_q <= 4'(CS_SETUP_CYC - 1); // [R16]
         end else if (state_q == ST_GUARD && guard_q != 4'h0) begin
            guard_q <= guard_q - 4'h1;
         end
      end
   end

   // ***********************************************
   // Input shift and command decode
   // ***********************************************
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         rise_q <= '0;
         in_sh_q <= '0;
         cmd_q <= CHAN_ZERO;
         fmt_q <= CFG_RESET; // [R22]
         setup_q <= CFG_RESET; // [R22]
      end else if (clk_en) begin
         if (state_q != ST_XFER) begin
            rise_q <= '0;
         end else if (sclk_rise && rise_q < IN_BITS) begin
            // Only the first eight rising edges sample data [R8] [R9]
            rise_q <= rise_q + 5'h01;
            in_sh_q <= {in_sh_q[5:0], din}; // [R8]
            if (rise_q == IN_BITS - 5'h01) begin
               // Upper nibble is command, lower is configuration [R3]
               if (in_sh_q[6:3] == CMD_SETUP) begin
                  setup_q <= {in_sh_q[2:0], din}; // [R6] [R5] [R25] [R18]
               end else begin
                  fmt_q <= {in_sh_q[2:0], din}; // [R4] [R19]
                  cmd_q <= in_sh_q[6:3]; // [R24]
               end
            end
         end
      end
   end

   // ***********************************************
   // Falling-edge count, sampling and conversion start
   // ***********************************************
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         fall_q <= '0;
         len_q <= LEN_16;
         sampling <= 1'b0;
         conv_start_q <= 1'b0;
         power_down <= 1'b0;
      end else if (clk_en) begin
         conv_start_q <= 1'b0;
         if (state_q == ST_IDLE || state_q == ST_WAIT) begin
            fall_q <= '0;
            // Length is fixed for the whole cycle at its start [R7]
            len_q <= len_now;
         end else if (state_q == ST_XFER && sclk_fall) begin
            fall_q <= fall_q + 5'h01;
            if (fall_q + 5'h01 == SAMPLE_EDGE) begin
               sampling <= (in_sh_q[3:0] != CMD_PWRDN) || dflt; // [R11]
            end
            if (fall_q + 5'h01 == len_q) begin
               sampling <= 1'b0; // [R11]
               power_down <= (cmd_q == CMD_PWRDN) && !dflt; // [R24]
               conv_start_q <= (cmd_q != CMD_PWRDN) || dflt; // [R12]
            end
         end
      end
   end

   // ***********************************************
   // Status output: end of conversion or done
   // ***********************************************
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         eoc_int <= 1'b1; // [R22]
      end else if (clk_en) begin
         if (int_mode) begin
            if (latch) begin
               eoc_int <= 1'b0; // [R23]
            end else if (cs_fall ||
                         (state_q == ST_XFER && sclk_rise)) begin
               eoc_int <= 1'b1; // [R23]
            end
         end else if (latch) begin
            eoc_int <= 1'b1; // [R13]
         end else if (conv_start_q) begin
            eoc_int <= 1'b0; // [R12]
         end else if (!conv_busy && !fifo_valid) begin
            eoc_int <= 1'b1;
         end
      end
   end

   // ***********************************************
   // Data output shifter
   // ***********************************************
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         out_sh_q <= '0;
         data_out <= 1'b0;
         data_out_oe <= 1'b0;
      end else if (clk_en) begin
         if (!cs_low) begin
            data_out_oe <= 1'b0; // [R1]
         end else if (state_q == ST_IDLE && cs_fall) begin
            // Previous result goes out from select fall [R14] [R10]
            data_out_oe <= 1'b1; // [R2]
            out_sh_q <= result_q;
            data_out <= result_q[WORD_W-1]; // [R14]
         end else if (new_cycle) begin
            out_sh_q <= fifo_word;
            data_out <= fifo_word[WORD_W-1]; // [R13]
         end else if (state_q == ST_XFER && sclk_fall) begin
            out_sh_q <= {out_sh_q[WORD_W-2:0], 1'b0};
            data_out <= out_sh_q[WORD_W-2]; // [R15] [R10]
         end
      end
   end

   // ***********************************************
   // Analog controls
   // ***********************************************
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         analog_channel <= CHAN_ZERO;
         ref_select <= REF_EXTERNAL;
      end else if (clk_en) begin
         // Setup write with default clear takes effect next cycle [R20]
         analog_channel <= chan_now; // [R21]
         ref_select <= dflt ? REF_EXTERNAL : setup_q[3:SET_REF_LO]; // [R5]
      end
   end
endmodule
`default_nettype wire

/* verif/adcsp_host_model.sv */
// Host serial port model that drives the converter's control pins
`timescale 1ns/1ns
`default_nettype none
module adcsp_host_model (
   // Clock
   input wire logic mclk,
   // Pins driven by the host
   output logic cs_n_pin,
   output logic io_clk_pin,
   output logic data_in_pin,
   // Pins driven by the device
   input wire logic data_out,
   input wire logic data_out_oe
);
   initial begin
      cs_n_pin = 1'b1;
      io_clk_pin = 1'b0;
      data_in_pin = 1'b0;
   end
   task automatic ticks(input int n);
      repeat (n) @(negedge mclk);
   endtask
   // One I/O cycle: byte out MSB first, result bits in, left aligned
   task automatic xfer(input logic [7:0] cmd, input int nclk,
         input logic hold_cs, input logic [15:0] junk,
         output logic [15:0] rx);
      rx = 16'h0000;
      if (cs_n_pin) begin
         cs_n_pin = 1'b0;
         ticks(12); // Wait out the select guard before clocking
      end
      for (int i = 0; i < nclk; i++) begin
         data_in_pin = (i < 8) ? cmd[7-i] : junk[i];
         ticks(4);
         io_clk_pin = 1'b1;
         ticks(2);
         rx[15-i] = data_out;
         ticks(2);
         io_clk_pin = 1'b0; // Exactly the selected count of clocks
      end
      ticks(2);
      // Released data line toggles so a stale level is never trusted
      data_in_pin = ~data_in_pin;
      if (!hold_cs) begin
         cs_n_pin = 1'b1;
         ticks(8);
      end
   endtask
endmodule
`default_nettype wire

/* verif/adcsp_top_sva.sv */
// Concurrent checks on the converter serial port pins
`timescale 1ns/1ns
`default_nettype none
module adcsp_top_sva
   import adcsp_pkg::*;
(
   // Clock and reset
   input wire logic mclk,
   input wire logic reset_n,
   // Serial pins
   input wire logic cs_n_pin,
   input wire logic io_clk_pin,
   input wire logic data_out,
   input wire logic data_out_oe,
   input wire logic eoc_int,
   // Front end status
   input wire logic sampling,
   input wire logic power_down
);
   // Cycles since the sample was last held; saturates
   logic [7:0] since_q;
   always_ff @(posedge mclk) begin
      if (!reset_n || $fell(sampling)) since_q <= 8'h00;
      else if (since_q != 8'hff) since_q <= since_q + 8'h01;
   end
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!reset_n);
   a_idle_float: assert property (cs_n_pin [*6] |-> !data_out_oe)
      else $error("data output driven while deselected");
   a_sel_drive: assert property (!cs_n_pin [*6] |-> data_out_oe)
      else $error("data output floating while selected");
   a_oe_release: assert property ($fell(data_out_oe) |-> $past(cs_n_pin, 2))
      else $error("data output released while selected");
   a_samp_span: assert property ($rose(sampling) |-> sampling [*8])
      else $error("sampling window too short");
   a_samp_idle: assert property (cs_n_pin [*6] |-> !sampling)
      else $error("sampling while deselected");
   a_status_fall: assert property ($fell(eoc_int) |->
      since_q <= 8'h06 || since_q >= CONV_CYC)
      else $error("status fell neither at start nor at latch");
   a_conv_done: assert property ($rose(eoc_int) |-> since_q >= CONV_CYC)
      else $error("status rose before conversion time");
   a_dout_hold: assert property (io_clk_pin [*4] |-> $stable(data_out))
      else $error("data output changed while clock high");
   c_status: cover property ($fell(eoc_int));
   c_pwrdn: cover property ($rose(power_down));
   c_sample: cover property ($rose(sampling));
endmodule
bind adcsp_top adcsp_top_sva u_sva (
   .mclk(mclk), .reset_n(reset_n), .cs_n_pin(cs_n_pin),
   .io_clk_pin(io_clk_pin), .data_out(data_out), .data_out_oe(data_out_oe),
   .eoc_int(eoc_int), .sampling(sampling), .power_down(power_down)
);
`default_nettype wire

/* verif/tb.sv */
// Self-checking bench for the converter serial port
`timescale 1ns/1ns
`default_nettype none
module tb;
   import adcsp_pkg::*;
   logic mclk = 1'b0;
   logic reset_n, cs_n_pin, io_clk_pin, data_in_pin, data_out, data_out_oe;
   logic eoc_int, sampling, power_down, dflt, int_mode, prev_ok;
   logic [CODE_W-1:0] sample_code;
   logic [3:0] analog_channel, last_fmt;
   logic [1:0] ref_select;
   logic [15:0] rx, prev_w;
   logic [31:0] seed = 32'h00017167;
   int err_count, comparisons, prev_n;
   always #10 mclk = ~mclk;
   adcsp_top uut (.mclk(mclk), .reset_n(reset_n), .clk_en(1'b1),
      .cs_n_pin(cs_n_pin), .io_clk_pin(io_clk_pin), .data_in_pin(data_in_pin),
      .data_out(data_out), .data_out_oe(data_out_oe), .eoc_int(eoc_int),
      .sample_code(sample_code), .analog_channel(analog_channel),
      .ref_select(ref_select), .sampling(sampling), .power_down(power_down));
   adcsp_host_model host (.mclk(mclk), .cs_n_pin(cs_n_pin),
      .io_clk_pin(io_clk_pin), .data_in_pin(data_in_pin),
      .data_out(data_out), .data_out_oe(data_out_oe));
   // *****
   // Expectation helpers
   // *****
   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic int len_of(input logic [1:0] sel);
      return (sel == LEN_SEL_8) ? 8 : (sel == LEN_SEL_16) ? 16 : 12;
   endfunction
   function automatic logic [15:0] exp_word(input logic [11:0] code,
         input int n, input logic lsb, input logic bip);
      logic [11:0] c;
      logic [15:0] w;
      c = bip ? code ^ BIPOLAR_FLIP : code;
      w = {c, 4'h0};
      if (lsb) for (int i = 0; i < 12; i++) w[15-i] = c[i];
      if (lsb && n == 8) for (int i = 0; i < 8; i++) w[15-i] = c[4+i];
      return w;
   endfunction
   task automatic chk_word(input logic [15:0] got, input logic [15:0] exp,
         input int n);
      logic [15:0] m;
      m = 16'hffff << (16 - n);
      comparisons++;
      if ((got & m) !== (exp & m)) begin
         err_count++;
         $display("ERROR %0t result %h expected %h", $time, got & m, exp & m);
      end
   endtask
   task automatic chk_pin(input logic [3:0] got, input logic [3:0] exp);
      comparisons++;
      if (got !== exp) begin
         err_count++;
         $display("ERROR %0t pins %b expected %b", $time, got, exp);
      end
   endtask
   task automatic final_report();
      $display("Comparisons %0d mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic end_test(input string name);
      $display("Test %s done", name);
   endtask
   // Bounded wait for the result latch; the status level depends on mode
   task automatic wait_done();
      int t;
      t = 0;
      repeat (12) @(negedge mclk);
      while (eoc_int !== ~int_mode && t < 400) begin
         @(negedge mclk);
         t++;
      end
      chk_pin({3'h0, eoc_int}, {3'h0, ~int_mode});
   endtask
   task automatic run(input logic [3:0] cmd, input logic [3:0] fmt,
         input logic hold);
      int n, m;
      logic [11:0] code;
      // Cycle length is the format in force; the new one sets the next
      n = dflt ? 16 : len_of(last_fmt[3:2]);
      m = dflt ? 16 : len_of(fmt[3:2]);
      seed = lfsr_next(seed);
      sample_code = seed[11:0];
      code = (cmd == CMD_TEST_MID) ? TEST_MID_CODE :
         (cmd == CMD_TEST_LO) ? TEST_LO_CODE :
         (cmd == CMD_TEST_HI) ? TEST_HI_CODE : seed[11:0];
      host.xfer({cmd, fmt}, n, hold, seed[31:16], rx);
      if (prev_ok) chk_word(rx, prev_w, (n < prev_n) ? n : prev_n);
      if (cmd != CMD_PWRDN) chk_pin(analog_channel, dflt ? CHAN_ZERO : cmd);
      if (int_mode) chk_pin({3'h0, eoc_int}, 4'h1);
      prev_w = exp_word(code, m, fmt[FMT_LSB_FIRST] & ~dflt,
         fmt[FMT_BIPOLAR]);
      prev_n = m;
      prev_ok = (cmd != CMD_PWRDN);
      last_fmt = fmt;
      wait_done();
   endtask
   task automatic setup(input logic [3:0] cfg, input logic [15:0] junk);
      host.xfer({CMD_SETUP, cfg}, dflt ? 16 : len_of(last_fmt[3:2]), 1'b0,
         junk, rx);
      dflt = cfg[SET_DEFAULT];
      int_mode = cfg[SET_INT_MODE] & ~cfg[SET_DEFAULT];
      prev_ok = 1'b0;
      wait_done();
      chk_pin({2'h0, ref_select}, {2'h0, dflt ? REF_EXTERNAL : cfg[3:2]});
   endtask
   // *****
   // Main sequence
   // *****
   initial begin
      reset_n = 1'b0;
      sample_code = 12'h000;
      {dflt, int_mode, prev_ok} = 3'h0;
      last_fmt = 4'h0;
      repeat (6) @(negedge mclk);
      reset_n = 1'b1;
      @(negedge mclk);
      chk_pin({eoc_int, data_out_oe, sampling, power_down}, 4'h8);
      chk_pin({ref_select, analog_channel[1:0]}, 4'h0);
      end_test("reset");
      setup(4'hc, 16'h0000);
      run(4'h3, 4'h0, 1'b0);
      for (int k = 0; k < 14; k++) begin
         run(seed[3:0] % 4'he, seed[7:4], 1'b0);
      end
      end_test("random");
      for (int k = 0; k < 3; k++) run(4'h6, 4'h0, k < 2);
      end_test("held select");
      setup(4'h2, 16'h0000);
      run(4'h9, 4'h8, 1'b0);
      run(4'ha, 4'h8, 1'b0);
      setup(4'h0, 16'h0000);
      end_test("done signal");
      run(CMD_PWRDN, 4'hc, 1'b0);
      chk_pin({3'h0, power_down}, 4'h1);
      end_test("power down");
      setup(4'hf, 16'hffff);
      run(4'h5, 4'h7, 1'b0);
      run(4'h4, 4'hd, 1'b0);
      setup(4'hc, 16'h0000);
      run(4'h2, 4'h4, 1'b0);
      run(4'h1, 4'h4, 1'b0);
      end_test("default mode");
      final_report();
   end
   initial begin
      repeat (60000) @(posedge mclk);
      err_count++;
      $display("ERROR %0t watchdog expired", $time);
      final_report();
   end
endmodule
`default_nettype wire
